// ---- pkg/fbm_pkg.sv ----
package fbm_pkg;
    // ----------------------------------------------------------------
    // widths and address fields (word addresses)
    // ----------------------------------------------------------------
    localparam int ADDR_W = 25;
    localparam int DATA_W = 16;
    localparam int BLK_W = 10;
    localparam int REGION_W = 6;
    localparam int BURST_LEN = 4;
    localparam int DIE_PICK_ADDRESS_BIT = 24;
    localparam int MAIN_HI = 23;
    localparam int MAIN_LO = 16;
    localparam int PARAM_HI = 15;
    localparam int PARAM_LO = 14;
    localparam int REGION_HI = 24;
    localparam int REGION_LO = 19;
    localparam int CFG_SYNC_BIT = 0;
    localparam logic [7:0] MAIN_BOT = 8'h00;
    localparam logic [7:0] MAIN_TOP = 8'hff;
    localparam logic [9:0] PARAM_OFS = 10'h003;
    localparam logic [9:0] DIE_BLKS = 10'h103;
    localparam logic [31:0] CNT_ONE = 32'h00000001;
    localparam logic [1:0] BCNT_LAST = 2'h3;
    localparam logic [1:0] BCNT_FIRST = 2'h1;
    localparam logic SYNC_MODE_RST = 1'b0;

    // ----------------------------------------------------------------
    // types
    // ----------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_READ = 3'h0,
        OP_PROG = 3'h1,
        OP_ERASE = 3'h2,
        OP_SUSP = 3'h3,
        OP_RESUME = 3'h4,
        OP_CFG = 3'h5,
        OP_CLR = 3'h6
    } fbm_op_e;

    typedef enum logic [5:0] {
        W_IDLE = 6'h01,
        W_PROG = 6'h02,
        W_ERASE = 6'h04,
        W_PSUSP = 6'h08,
        W_ESUSP = 6'h10,
        W_EPROG = 6'h20
    } fbm_wst_e;

    typedef enum logic [3:0] {
        R_IDLE = 4'h1,
        R_ISSUE = 4'h2,
        R_CAPT = 4'h4,
        R_HAND = 4'h8
    } fbm_rst_e;

    typedef struct packed {
        fbm_op_e op;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
    } fbm_cmd_s;

    typedef struct packed {
        logic ready;
        logic erase_err;
        logic prog_err;
        logic vpp_err;
        logic seq_err;
        logic erase_susp;
        logic prog_susp;
        logic sync_mode;
    } fbm_status_s;

    typedef struct packed {
        logic [BURST_LEN-1:0][DATA_W-1:0] word;
    } fbm_burst_s;
endpackage

// ---- src/fbm_flash_ctrl.sv ----
`timescale 1ns/1ps
module fbm_flash_ctrl #(
    parameter int unsigned PROG_CYCLES = 2000,
    parameter int unsigned ERASE_CYCLES = 100000
) (
    input wire logic clk_sys_i,
    input wire logic resetn_i,
    input wire logic burst_clk_i,
    input wire logic stacked_flash_select_low_n_i,
    input wire logic vpp_over_program_supply_lockout_level_i,
    input wire logic cmd_valid_i,
    input wire fbm_pkg::fbm_cmd_s cmd_i,
    output logic cmd_ready_o,
    output logic rd_valid_o,
    output logic [fbm_pkg::DATA_W-1:0] rd_data_o,
    output logic rd_err_o,
    output fbm_pkg::fbm_status_s status_o,
    output logic die_lower_sel_o,
    output logic die_upper_sel_o,
    output logic arr_rd_o,
    output logic [fbm_pkg::ADDR_W-1:0] arr_addr_o,
    input wire logic [fbm_pkg::DATA_W-1:0] arr_rdata_i,
    output logic arr_we_o,
    output logic [fbm_pkg::DATA_W-1:0] arr_wdata_o,
    output logic arr_erase_o,
    output logic [fbm_pkg::BLK_W-1:0] arr_blk_o,
    output logic [fbm_pkg::REGION_W-1:0] arr_region_o,
    output logic [fbm_pkg::DATA_W-1:0] burst_data_o,
    output logic burst_wait_o
);
    import fbm_pkg::*;

    // ----------------------------------------------------------------
    // block map: lower die bottom params, upper die top params
    // ----------------------------------------------------------------
    function automatic logic [BLK_W-1:0] blk_index(
        input logic [ADDR_W-1:0] a
    );
        logic [7:0] main_f;
        logic [9:0] prm;
        main_f = a[MAIN_HI:MAIN_LO];
        prm = {8'h00, a[PARAM_HI:PARAM_LO]};
        if (!a[DIE_PICK_ADDRESS_BIT]) begin
            if (main_f == MAIN_BOT) begin
                blk_index = prm;
            end else begin
                blk_index = {2'h0, main_f} + PARAM_OFS;
            end
        end else if (main_f == MAIN_TOP) begin
            blk_index = DIE_BLKS + {2'h0, MAIN_TOP} + prm;
        end else begin
            blk_index = DIE_BLKS + {2'h0, main_f};
        end
    endfunction

    // ----------------------------------------------------------------
    // reset release and pin synchronisers
    // ----------------------------------------------------------------
    logic rst_meta, rst_n, b_rst_meta, b_rst_n;
    logic cs_meta, cs_n_s, vpp_meta, vpp_ok;
    always_ff @(posedge clk_sys_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta <= 1'b0;
            rst_n <= 1'b0;
            cs_meta <= 1'b1;
            cs_n_s <= 1'b1;
            vpp_meta <= 1'b0;
            vpp_ok <= 1'b0;
        end else begin
            rst_meta <= 1'b1;
            rst_n <= rst_meta;
            cs_meta <= stacked_flash_select_low_n_i;
            cs_n_s <= cs_meta;
            vpp_meta <= vpp_over_program_supply_lockout_level_i;
            vpp_ok <= vpp_meta;
        end
    end
    always_ff @(posedge burst_clk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            b_rst_meta <= 1'b0;
            b_rst_n <= 1'b0;
        end else begin
            b_rst_meta <= 1'b1;
            b_rst_n <= b_rst_meta;
        end
    end

    // ----------------------------------------------------------------
    // command front end
    // ----------------------------------------------------------------
    fbm_wst_e wstate_reg, wstate_next;
    fbm_rst_e rstate_reg, rstate_next;
    logic acc, cs_act;
    assign cs_act = !cs_n_s;
    assign cmd_ready_o = cs_act &&
        (cmd_i.op != OP_READ || rstate_reg == R_IDLE);
    assign acc = cmd_valid_i && cmd_ready_o;

    // ----------------------------------------------------------------
    // write automaton
    // ----------------------------------------------------------------
    logic [31:0] prog_cnt_reg, prog_cnt_next, erase_cnt_reg, erase_cnt_next;
    logic [ADDR_W-1:0] prog_addr_reg, prog_addr_next;
    logic [ADDR_W-1:0] erase_addr_reg, erase_addr_next;
    logic [DATA_W-1:0] prog_data_reg, prog_data_next;
    logic [BLK_W-1:0] erase_blk_reg, erase_blk_next;
    logic [3:0] err_reg, err_next, err_set;
    logic sync_mode_reg, sync_mode_next, err_clr, we_next, erase_next;
    logic we_reg, erase_reg;
    always_comb begin
        wstate_next = wstate_reg;
        prog_cnt_next = prog_cnt_reg;
        erase_cnt_next = erase_cnt_reg;
        prog_addr_next = prog_addr_reg;
        prog_data_next = prog_data_reg;
        erase_addr_next = erase_addr_reg;
        erase_blk_next = erase_blk_reg;
        sync_mode_next = sync_mode_reg;
        err_set = 4'h0; // erase, prog, vpp, sequence
        err_clr = 1'b0;
        we_next = 1'b0;
        erase_next = 1'b0;
        // a supply drop mid-operation aborts it with an error
        if (wstate_reg == W_PROG || wstate_reg == W_EPROG) begin
            if (!vpp_ok) begin
                err_set = 4'h6;
                wstate_next = (wstate_reg == W_PROG) ? W_IDLE : W_ESUSP;
            end else if (prog_cnt_reg == CNT_ONE) begin
                we_next = 1'b1;
                wstate_next = (wstate_reg == W_PROG) ? W_IDLE : W_ESUSP;
            end else begin
                prog_cnt_next = prog_cnt_reg - CNT_ONE;
            end
        end
        if (wstate_reg == W_ERASE) begin
            if (!vpp_ok) begin
                err_set = 4'ha;
                wstate_next = W_IDLE;
            end else if (erase_cnt_reg == CNT_ONE) begin
                erase_next = 1'b1;
                wstate_next = W_IDLE;
            end else begin
                erase_cnt_next = erase_cnt_reg - CNT_ONE;
            end
        end
        if (acc) begin
            case (cmd_i.op)
                OP_PROG: begin
                    // errors are or-ed in so an abort in this cycle stays
                    if (!vpp_ok) begin
                        err_set = err_set | 4'h6;
                    end else if (wstate_reg == W_IDLE ||
                        (wstate_reg == W_ESUSP &&
                        blk_index(cmd_i.addr) != erase_blk_reg)) begin
                        prog_addr_next = cmd_i.addr;
                        prog_data_next = cmd_i.data;
                        prog_cnt_next = 32'(PROG_CYCLES);
                        wstate_next = (wstate_reg == W_IDLE) ?
                            W_PROG : W_EPROG;
                    end else begin
                        err_set = err_set | 4'h1;
                    end
                end
                OP_ERASE: begin
                    if (!vpp_ok) begin
                        err_set = err_set | 4'ha;
                    end else if (wstate_reg != W_IDLE) begin
                        err_set = err_set | 4'h1;
                    end else begin
                        erase_addr_next = cmd_i.addr;
                        erase_blk_next = blk_index(cmd_i.addr);
                        erase_cnt_next = 32'(ERASE_CYCLES);
                        wstate_next = W_ERASE;
                    end
                end
                OP_SUSP: begin
                    // no suspend in the completing cycle: work is done
                    if (wstate_reg == W_PROG && prog_cnt_reg > CNT_ONE &&
                        vpp_ok) begin
                        wstate_next = W_PSUSP;
                    end else if (wstate_reg == W_ERASE &&
                        erase_cnt_reg > CNT_ONE && vpp_ok) begin
                        wstate_next = W_ESUSP;
                    end
                end
                OP_RESUME: begin
                    if (wstate_reg == W_PSUSP) begin
                        wstate_next = W_PROG;
                    end else if (wstate_reg == W_ESUSP) begin
                        wstate_next = W_ERASE;
                    end
                end
                OP_CFG: begin
                    sync_mode_next = cmd_i.data[CFG_SYNC_BIT];
                end
                OP_CLR: begin
                    err_clr = 1'b1;
                end
                default: begin
                end
            endcase
        end
        // a new error outranks a clear in the same cycle
        err_next = (err_reg & ~{4{err_clr}}) | err_set;
    end
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            wstate_reg <= W_IDLE;
            prog_cnt_reg <= '0;
            erase_cnt_reg <= '0;
            prog_addr_reg <= '0;
            prog_data_reg <= '0;
            erase_addr_reg <= '0;
            erase_blk_reg <= '0;
            err_reg <= 4'h0;
            sync_mode_reg <= SYNC_MODE_RST;
            we_reg <= 1'b0;
            erase_reg <= 1'b0;
        end else begin
            wstate_reg <= wstate_next;
            prog_cnt_reg <= prog_cnt_next;
            erase_cnt_reg <= erase_cnt_next;
            prog_addr_reg <= prog_addr_next;
            prog_data_reg <= prog_data_next;
            erase_addr_reg <= erase_addr_next;
            erase_blk_reg <= erase_blk_next;
            err_reg <= err_next;
            sync_mode_reg <= sync_mode_next;
            we_reg <= we_next;
            erase_reg <= erase_next;
        end
    end
    assign status_o = '{ready: wstate_reg == W_IDLE ||
        wstate_reg == W_PSUSP || wstate_reg == W_ESUSP,
        erase_err: err_reg[3], prog_err: err_reg[2], vpp_err: err_reg[1],
        seq_err: err_reg[0], erase_susp: wstate_reg == W_ESUSP,
        prog_susp: wstate_reg == W_PSUSP, sync_mode: sync_mode_reg};
    assign arr_we_o = we_reg;
    assign arr_erase_o = erase_reg;
    assign arr_wdata_o = prog_data_reg;
    assign arr_blk_o = erase_blk_reg;

    // ----------------------------------------------------------------
    // read engine: page reads direct, burst reads via handshake
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] rd_addr_reg, rd_addr_next;
    logic [1:0] rcnt_reg, rcnt_next;
    logic rd_valid_reg, rd_valid_next, rd_err_reg, rd_err_next;
    logic [DATA_W-1:0] rd_data_reg, rd_data_next;
    fbm_burst_s bbuf_reg, bbuf_next;
    logic req_reg, req_next, ack_meta, ack_s, b_ack_reg, rd_ok;
    always_comb begin
        rd_ok = wstate_reg == W_IDLE ||
            (wstate_reg == W_PSUSP && cmd_i.addr != prog_addr_reg) ||
            (wstate_reg == W_ESUSP &&
             blk_index(cmd_i.addr) != erase_blk_reg);
        rstate_next = rstate_reg;
        rd_addr_next = rd_addr_reg;
        rcnt_next = rcnt_reg;
        rd_valid_next = 1'b0;
        rd_err_next = 1'b0;
        rd_data_next = rd_data_reg;
        bbuf_next = bbuf_reg;
        req_next = req_reg;
        case (rstate_reg)
            R_IDLE: begin
                if (acc && cmd_i.op == OP_READ) begin
                    if (rd_ok) begin
                        rd_addr_next = cmd_i.addr;
                        rcnt_next = 2'h0;
                        rstate_next = R_ISSUE;
                    end else begin
                        rd_valid_next = 1'b1;
                        rd_err_next = 1'b1;
                    end
                end
            end
            R_ISSUE: rstate_next = R_CAPT;
            R_CAPT: begin
                if (!sync_mode_reg) begin
                    rd_data_next = arr_rdata_i;
                    rd_valid_next = 1'b1;
                    rstate_next = R_IDLE;
                end else begin
                    bbuf_next.word[rcnt_reg] = arr_rdata_i;
                    rcnt_next = rcnt_reg + 2'h1;
                    rd_addr_next = rd_addr_reg + 25'h1;
                    if (rcnt_reg == BCNT_LAST) begin
                        req_next = !req_reg;
                        rstate_next = R_HAND;
                    end else begin
                        rstate_next = R_ISSUE;
                    end
                end
            end
            R_HAND: begin
                if (ack_s == req_reg) begin
                    rstate_next = R_IDLE;
                end
            end
            default: rstate_next = R_IDLE;
        endcase
    end
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            rstate_reg <= R_IDLE;
            rd_addr_reg <= '0;
            rcnt_reg <= 2'h0;
            rd_valid_reg <= 1'b0;
            rd_err_reg <= 1'b0;
            rd_data_reg <= '0;
            bbuf_reg <= '0;
            req_reg <= 1'b0;
            ack_meta <= 1'b0;
            ack_s <= 1'b0;
        end else begin
            rstate_reg <= rstate_next;
            rd_addr_reg <= rd_addr_next;
            rcnt_reg <= rcnt_next;
            rd_valid_reg <= rd_valid_next;
            rd_err_reg <= rd_err_next;
            rd_data_reg <= rd_data_next;
            bbuf_reg <= bbuf_next;
            req_reg <= req_next;
            ack_meta <= b_ack_reg;
            ack_s <= ack_meta;
        end
    end
    assign rd_valid_o = rd_valid_reg;
    assign rd_err_o = rd_err_reg;
    assign rd_data_o = rd_data_reg;
    assign arr_rd_o = rstate_reg == R_ISSUE;

    // ----------------------------------------------------------------
    // array address and die selection
    // ----------------------------------------------------------------
    logic [ADDR_W-1:0] arr_addr_reg, arr_addr_next;
    logic [1:0] die_reg, die_next;
    always_comb begin
        arr_addr_next = we_next ? prog_addr_reg :
            (erase_next ? erase_addr_reg : rd_addr_next);
        die_next = die_reg;
        if (!cs_act) begin
            die_next = 2'b00;
        end else if (cmd_valid_i) begin
            die_next = {cmd_i.addr[DIE_PICK_ADDRESS_BIT],
                !cmd_i.addr[DIE_PICK_ADDRESS_BIT]};
        end
    end
    always_ff @(posedge clk_sys_i or negedge rst_n) begin
        if (!rst_n) begin
            arr_addr_reg <= '0;
            die_reg <= 2'b00;
        end else begin
            arr_addr_reg <= arr_addr_next;
            die_reg <= die_next;
        end
    end
    assign arr_addr_o = arr_addr_reg;
    assign arr_region_o = arr_addr_reg[REGION_HI:REGION_LO];
    assign die_lower_sel_o = die_reg[0];
    assign die_upper_sel_o = die_reg[1];

    // ----------------------------------------------------------------
    // burst clock side; buffer held stable until ack returns
    // ----------------------------------------------------------------
    logic b_req_meta, b_req_s1, b_req_s2, b_act_reg, b_act_next;
    logic [1:0] b_cnt_reg, b_cnt_next;
    logic b_wait_reg, b_wait_next, b_ack_next;
    logic [DATA_W-1:0] b_data_reg, b_data_next;
    always_comb begin
        b_act_next = b_act_reg;
        b_cnt_next = b_cnt_reg;
        b_wait_next = b_wait_reg;
        b_ack_next = b_ack_reg;
        b_data_next = b_data_reg;
        if (!b_act_reg && (b_req_s1 ^ b_req_s2)) begin
            b_data_next = bbuf_reg.word[0];
            b_wait_next = 1'b0;
            b_cnt_next = BCNT_FIRST;
            b_act_next = 1'b1;
        end else if (b_act_reg) begin
            if (b_cnt_reg == 2'h0) begin
                b_wait_next = 1'b1;
                b_act_next = 1'b0;
                b_ack_next = !b_ack_reg;
            end else begin
                b_data_next = bbuf_reg.word[b_cnt_reg];
                b_cnt_next = b_cnt_reg + 2'h1;
            end
        end
    end
    always_ff @(posedge burst_clk_i or negedge b_rst_n) begin
        if (!b_rst_n) begin
            b_req_meta <= 1'b0;
            b_req_s1 <= 1'b0;
            b_req_s2 <= 1'b0;
            b_act_reg <= 1'b0;
            b_cnt_reg <= 2'h0;
            b_wait_reg <= 1'b1;
            b_ack_reg <= 1'b0;
            b_data_reg <= '0;
        end else begin
            b_req_meta <= req_reg;
            b_req_s1 <= b_req_meta;
            b_req_s2 <= b_req_s1;
            b_act_reg <= b_act_next;
            b_cnt_reg <= b_cnt_next;
            b_wait_reg <= b_wait_next;
            b_ack_reg <= b_ack_next;
            b_data_reg <= b_data_next;
        end
    end
    assign burst_data_o = b_data_reg;
    assign burst_wait_o = b_wait_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    chk_boot_async: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        $changed(sync_mode_reg) |-> $past(acc && cmd_i.op == OP_CFG))
        else $error("read mode changed without config command");
    chk_cfg_take: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        acc && cmd_i.op == OP_CFG |=> sync_mode_reg == $past(cmd_i.data[0]))
        else $error("config command did not set read mode");
    chk_vpp_refuse: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        acc && (cmd_i.op == OP_PROG || cmd_i.op == OP_ERASE) && !vpp_ok
        |=> err_reg[1] && !(wstate_reg inside {W_PROG, W_ERASE, W_EPROG}))
        else $error("array change accepted under lockout");
    chk_prog_word: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        wstate_reg == W_PROG && prog_cnt_reg == CNT_ONE && vpp_ok
        |=> arr_we_o && arr_addr_o == $past(prog_addr_reg) &&
        wstate_reg == W_IDLE)
        else $error("program did not complete one word");
    // the erase counter bounds the run; no long delay range needed
    chk_erase_block: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        acc && cmd_i.op == OP_ERASE && wstate_reg == W_IDLE && vpp_ok
        |=> erase_blk_reg == blk_index($past(cmd_i.addr)) &&
        wstate_reg == W_ERASE && erase_cnt_reg == 32'(ERASE_CYCLES))
        else $error("erase block not taken from address");
    chk_esusp_read: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        acc && cmd_i.op == OP_READ && wstate_reg == W_ESUSP &&
        blk_index(cmd_i.addr) != erase_blk_reg && !sync_mode_reg
        |-> ##3 rd_valid_o && !rd_err_o)
        else $error("read during erase suspend refused");
    chk_psusp_clash: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        acc && cmd_i.op == OP_READ && wstate_reg == W_PSUSP &&
        cmd_i.addr == prog_addr_reg |=> rd_valid_o && rd_err_o)
        else $error("read of word under program not refused");
    chk_die_pick: assert property (@(posedge clk_sys_i)
        disable iff (!rst_n)
        cs_act && cmd_valid_i |=> die_upper_sel_o ==
        $past(cmd_i.addr[DIE_PICK_ADDRESS_BIT]) &&
        die_lower_sel_o != die_upper_sel_o)
        else $error("wrong die selected");
    chk_burst_wait: assert property (@(posedge burst_clk_i)
        disable iff (!b_rst_n)
        $fell(b_wait_reg) |-> !b_wait_reg [*4] ##1 b_wait_reg)
        else $error("wait not low for exactly four words");
endmodule

// ---- verification/fbm_array_model.sv ----
`timescale 1ns/1ps
// ----
// array model: unwritten words read as inverted address
// ----
module fbm_array_model (
    input wire logic clk_sys_i,
    input wire logic we_i,
    input wire logic [24:0] addr_i,
    input wire logic [15:0] wdata_i,
    output logic [15:0] rdata_o
);
    logic [15:0] mem [logic [24:0]];
    logic upd = 1'b0;
    always @(posedge clk_sys_i) if (we_i === 1'b1) begin
        mem[addr_i] = wdata_i;
        upd = ~upd;
    end
    // word addressed, follows the held address
    always @(addr_i or upd)
        rdata_o = mem.exists(addr_i) ? mem[addr_i] : ~addr_i[15:0];
endmodule

// ---- verification/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
    import fbm_pkg::*;
    logic clk_sys_i = 1'b0;
    logic burst_clk_i = 1'b0;
    logic resetn_i = 1'b0;
    logic vpp = 1'b1;
    logic cs_n = 1'b0;
    logic v = 1'b0;
    fbm_cmd_s c = '0;
    fbm_status_s st;
    logic rdy, rv, re, lo, up, rd, we, er, bw;
    logic [15:0] rdat, wdat, ardat, bdat;
    logic [24:0] aa;
    logic [9:0] blk;
    logic [5:0] rg;
    int miscompares = 0;
    int checks = 0;
    int nwe = 0;
    int nrd = 0;
    logic [7:0] lf = 8'h4a;
    logic [15:0] mem [logic [24:0]];
    logic [15:0] bq [$];
    wire [4:0] ev = {rdy, ~bw, rv, er, we};
    always #5 clk_sys_i = ~clk_sys_i;
    always #7.5 burst_clk_i = ~burst_clk_i;
    always @(posedge burst_clk_i) if (bw === 1'b0) bq.push_back(bdat);
    always @(posedge clk_sys_i) if (we === 1'b1) nwe++;
    always @(posedge clk_sys_i) if (rd === 1'b1) nrd++;
    fbm_flash_ctrl #(.PROG_CYCLES(4), .ERASE_CYCLES(8)) fbm_flash_ctrl_i (
        .clk_sys_i(clk_sys_i), .resetn_i(resetn_i), .burst_clk_i(burst_clk_i),
        .stacked_flash_select_low_n_i(cs_n),
        .vpp_over_program_supply_lockout_level_i(vpp),
        .cmd_valid_i(v), .cmd_i(c), .cmd_ready_o(rdy), .rd_valid_o(rv),
        .rd_data_o(rdat), .rd_err_o(re), .status_o(st),
        .die_lower_sel_o(lo), .die_upper_sel_o(up), .arr_rd_o(rd),
        .arr_addr_o(aa), .arr_rdata_i(ardat), .arr_we_o(we),
        .arr_wdata_o(wdat), .arr_erase_o(er), .arr_blk_o(blk),
        .arr_region_o(rg), .burst_data_o(bdat), .burst_wait_o(bw));
    fbm_array_model fbm_array_model_i (.clk_sys_i(clk_sys_i), .we_i(we),
        .addr_i(aa), .wdata_i(wdat), .rdata_o(ardat));
    // ----
    // reference model and helpers
    // ----
    function automatic logic [15:0] ex(input logic [24:0] a);
        return mem.exists(a) ? mem[a] : ~a[15:0];
    endfunction
    function automatic logic [7:0] lfsr(input logic [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction
    function automatic logic [9:0] bix(input logic [24:0] a);
        if (!a[24]) return a[23:16] == 8'h00 ? {8'h00, a[15:14]}
            : {2'h0, a[23:16]} + 10'h003;
        return a[23:16] == 8'hff ? 10'h202 + {8'h00, a[15:14]}
            : 10'h103 + {2'h0, a[23:16]};
    endfunction
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        checks++;
        if (g !== e) begin
            miscompares++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    task automatic finish_test;
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic step(input int k);
        repeat (k) @(posedge clk_sys_i);
        #1;
    endtask
    task automatic wfor(input int k);
        int n;
        n = 0;
        while (ev[k] !== 1'b1 && n < 300) begin
            step(1);
            n++;
        end
        if (n == 300) begin
            miscompares++;
            finish_test;
        end
    endtask
    task automatic cmd(input fbm_op_e op, input logic [24:0] a,
        input logic [15:0] d);
        step(1);
        c = '{op, a, d};
        v = 1'b1;
        wfor(4);
        step(1);
        v = 1'b0;
    endtask
    // ----
    // main sequence
    // ----
    initial begin
        logic [24:0] a;
        logic [15:0] d;
        int k;
        logic [24:0] et [7] = '{25'h0, 25'hc000, 25'h10000, 25'hff0000,
            25'h1000000, 25'h1fe0000, 25'h1ffc000};
        step(4);
        resetn_i = 1'b1;
        step(8);
        chk(st, 8'h80);
        for (int i = 0; i < 2; i++) begin
            lf = lfsr(lf);
            a = {i[0], lf, ~lf, lf};
            d = {lf, ~lf};
            mem[a] = d;
            cmd(OP_PROG, a, d);
            chk({up, lo}, i ? 2 : 1);
            wfor(0);
            chk({aa, wdat}, {a, d});
            cmd(OP_READ, a, 16'h0);
            wfor(2);
            chk({re, rdat}, {1'b0, ex(a)});
        end
        cs_n = 1'b1;
        step(3);
        chk({rdy, up, lo}, 3'b000);
        cs_n = 1'b0;
        step(3);
        vpp = 1'b0;
        step(3);
        k = nwe;
        cmd(OP_PROG, a, ~d);
        cmd(OP_ERASE, a, 16'h0);
        step(8);
        chk({st.erase_err, st.prog_err, st.vpp_err}, 3'b111);
        chk(nwe, k);
        vpp = 1'b1;
        cmd(OP_CLR, 25'h0, 16'h0);
        step(3);
        chk(st, 8'h80);
        foreach (et[j]) begin
            a = et[j] | {11'h0, lf[5:0], 8'h00};
            cmd(OP_ERASE, a, 16'h0);
            wfor(1);
            chk({blk, rg}, {bix(a), a[24:19]});
        end
        cmd(OP_ERASE, 25'h20000, 16'h0);
        cmd(OP_SUSP, 25'h0, 16'h0);
        chk({st.ready, st.erase_susp}, 2'b11);
        cmd(OP_PROG, 25'h20003, d);
        chk(st.seq_err, 1'b1);
        a = {9'h003, lf, ~lf};
        mem[a] = d;
        cmd(OP_PROG, a, d);
        wfor(0);
        chk({aa, wdat}, {a, d});
        cmd(OP_READ, a, 16'h0);
        wfor(2);
        chk({re, rdat}, {1'b0, ex(a)});
        cmd(OP_READ, 25'h2abcd, 16'h0);
        chk({rv, re}, 2'b11);
        cmd(OP_RESUME, 25'h0, 16'h0);
        wfor(1);
        chk(blk, bix(25'h20000));
        a = {9'h005, ~lf, lf};
        lf = lfsr(lf);
        d = {~lf, lf};
        mem[a] = d;
        cmd(OP_PROG, a, d);
        cmd(OP_SUSP, 25'h0, 16'h0);
        chk(st.prog_susp, 1'b1);
        cmd(OP_READ, a, 16'h0);
        chk({rv, re}, 2'b11);
        cmd(OP_READ, a ^ 25'h1, 16'h0);
        wfor(2);
        chk({re, rdat}, {1'b0, ex(a ^ 25'h1)});
        cmd(OP_RESUME, 25'h0, 16'h0);
        wfor(0);
        chk({aa, wdat}, {a, d});
        cmd(OP_CFG, 25'h0, 16'h1);
        step(1);
        chk(st.sync_mode, 1'b1);
        bq.delete();
        k = nrd;
        a = {1'b0, lf, ~lf, 8'h10};
        cmd(OP_READ, a, 16'h0);
        wfor(3);
        step(20);
        chk(bq.size(), 4);
        chk(nrd - k, 4);
        foreach (bq[j]) chk(bq[j], ex(a + j));
        finish_test;
    end
endmodule
